// *** inc/utm_defs.svh ***
// constants shared by the tag memory access ends
`ifndef UTM_DEFS_SVH
`define UTM_DEFS_SVH
`define UTM_INSTR_PROG_ENTER 8'h04
`define UTM_INSTR_PROG_EXIT 8'h05
`define UTM_INSTR_ERASE 8'h61
`define UTM_INSTR_WR_STAGE 8'h62
`define UTM_INSTR_RD_STAGE 8'h63
`define UTM_INSTR_PROG_ROW 8'h64
`define UTM_INSTR_RD_ROW 8'h65
`define UTM_KEY_HI 8'hE5
`define UTM_KEY_LO 8'h3D
`define UTM_ERASED_BYTE 8'hFF
`define UTM_ROW_BYTES 7
`define UTM_ROWS 16
`define UTM_ROW_LSB 4
`endif

// *** inc/utm_pkg.sv ***
// types shared by the tag memory access ends
package utm_pkg;
    // link token kinds, one per bus event
    typedef enum logic [2:0] {
        UTM_TOK_START_WR = 3'h0,
        UTM_TOK_DATA = 3'h1,
        UTM_TOK_RSTART_RD = 3'h2,
        UTM_TOK_READ = 3'h3,
        UTM_TOK_STOP = 3'h4
    } utm_tok_e;
    // host user operations
    typedef enum logic [2:0] {
        UTM_OP_ENTER_PROG = 3'h0,
        UTM_OP_EXIT_PROG = 3'h1,
        UTM_OP_ERASE = 3'h2,
        UTM_OP_WRITE_STAGE = 3'h3,
        UTM_OP_READ_STAGE = 3'h4,
        UTM_OP_PROGRAM_ROW = 3'h5,
        UTM_OP_READ_ROW = 3'h6
    } utm_op_e;
endpackage

// *** inc/utm_link_if.sv ***
// transaction level link between host and tag memory device
`timescale 1ns/1ps
interface utm_link_if;
    // host to device tokens
    logic tok_valid;
    logic tok_ready;
    utm_pkg::utm_tok_e tok_kind;
    logic [7:0] tok_data;
    logic tok_last;
    // device to host read bytes
    logic rsp_valid;
    logic rsp_ready;
    logic [7:0] rsp_data;
    modport host (output tok_valid, output tok_kind, output tok_data, output tok_last, input tok_ready,
                  input rsp_valid, input rsp_data, output rsp_ready);
    modport dev (input tok_valid, input tok_kind, input tok_data, input tok_last, output tok_ready,
                 output rsp_valid, output rsp_data, input rsp_ready);
endinterface

// *** src/utm_dev.sv ***
// tag memory device end: staging register, array, programming engine and read buffer
// Function
// - seven-byte staging, sixteen rows of seven bytes
// - tag access blocked while fault logging enabled
// - host enters programming mode before tag access
// - instruction 0x61 erases whole array
// - host erases before reprogramming written rows
// - 0x62 loads staging bytes from byte 0
// - 0x63 then read returns staging bytes ascending
// - 0x64 copies staging into row from bits 7:4
// - host sends row in upper nibble, low zero
// - 0x65 row, repeated start, read row bytes
// - array read advances row after seventh byte
// - stop ends array read at any point
// - host nacks last wanted read byte
// - 0x04 with key 0xE53D enters programming mode
// - 0x05 returns device to normal operation
`timescale 1ns/1ps
`include "utm_defs.svh"

// two-entry buffer in front of the read data path
module utm_dev_buf #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    logic [1:0] cnt_reg; // entries held, 0 to 2
    logic [W-1:0] head_reg; // oldest entry
    logic [W-1:0] tail_reg; // second entry
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    // full only at two, so a stalled drain pushes back on the fill side
    assign in_ready_o = (cnt_reg != 2'h2);
    assign out_valid_o = (cnt_reg != 2'h0);
    assign out_data_o = head_reg;

    // occupancy count
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cnt_reg <= 2'h0;
        end else if (push && !pop) begin
            cnt_reg <= cnt_reg + 2'h1;
        end else if (pop && !push) begin
            cnt_reg <= cnt_reg - 2'h1;
        end
    end

    // data movement; head refills from tail or from the input
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            head_reg <= '0;
            tail_reg <= '0;
        end else begin
            if (pop) begin
                head_reg <= (cnt_reg == 2'h2) ? tail_reg : in_data_i;
            end else if (push && cnt_reg == 2'h0) begin
                head_reg <= in_data_i;
            end
            if (push && ((cnt_reg == 2'h1 && !pop) || cnt_reg == 2'h2)) begin
                tail_reg <= in_data_i;
            end
        end
    end
endmodule

module utm_dev #(
    parameter int ROWS = `UTM_ROWS,
    parameter int ROW_BYTES = `UTM_ROW_BYTES
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // link to host
    utm_link_if.dev link,
    // feature selection from surrounding logic
    input wire logic fault_log_en_i,
    // status
    output logic prog_mode_o,
    output logic erase_done_o,
    output logic row_prog_done_o
);
    localparam int ENTRIES = ROWS * ROW_BYTES;
    localparam int IW = $clog2(ENTRIES);
    localparam int RW = $clog2(ROWS);
    localparam int BW = $clog2(ROW_BYTES);
    localparam logic [BW-1:0] LAST_BYTE = BW'(ROW_BYTES - 1);
    localparam logic [RW-1:0] LAST_ROW = RW'(ROWS - 1);

    // read source selection
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_STAGE = 2'h1;
    localparam logic [1:0] SRC_ARRAY = 2'h2;

    logic [7:0] stage_reg [ROW_BYTES]; // staging register
    logic [7:0] mem_reg [ENTRIES]; // nonvolatile array, row major
    logic prog_mode_reg; // programming mode flag
    logic in_write_reg; // inside a write transaction
    logic [7:0] instr_reg; // instruction of current transaction
    logic [3:0] byte_cnt_reg; // bytes seen in write, saturates
    logic key_hi_ok_reg; // first key byte matched
    logic key_ok_reg; // both key bytes matched
    logic [RW-1:0] row_reg; // row from the row-address byte
    logic [1:0] src_reg; // what the read phase returns
    logic [RW-1:0] rd_row_reg; // array read row
    logic [BW-1:0] rd_byte_reg; // byte within row or staging
    logic erase_done_reg;
    logic row_prog_done_reg;

    // token decode
    wire fire = link.tok_valid && link.tok_ready;
    wire is_start = fire && link.tok_kind == utm_pkg::UTM_TOK_START_WR;
    wire is_data = fire && link.tok_kind == utm_pkg::UTM_TOK_DATA && in_write_reg;
    wire is_rstart = fire && link.tok_kind == utm_pkg::UTM_TOK_RSTART_RD;
    wire is_read = fire && link.tok_kind == utm_pkg::UTM_TOK_READ;
    wire is_stop = fire && link.tok_kind == utm_pkg::UTM_TOK_STOP;
    wire first_byte = is_data && byte_cnt_reg == 4'h0;
    wire arg_byte = is_data && byte_cnt_reg != 4'h0;
    wire [3:0] arg_idx = byte_cnt_reg - 4'h1;

    // array is shared with fault logging, so tag access needs both conditions
    wire access_ok = prog_mode_reg && !fault_log_en_i;

    // actions taken at stop of a write transaction; staging writes are taken per argument byte
    wire stop_wr = is_stop && in_write_reg;
    wire do_enter = stop_wr && instr_reg == `UTM_INSTR_PROG_ENTER && byte_cnt_reg == 4'h3 && key_ok_reg;
    wire do_exit = stop_wr && instr_reg == `UTM_INSTR_PROG_EXIT;
    wire do_erase = stop_wr && access_ok && instr_reg == `UTM_INSTR_ERASE;
    wire do_prog = stop_wr && access_ok && instr_reg == `UTM_INSTR_PROG_ROW && byte_cnt_reg == 4'h2;
    wire stage_wr = arg_byte && access_ok && instr_reg == `UTM_INSTR_WR_STAGE
                    && arg_idx < 4'(ROW_BYTES);

    // read data selection
    wire [IW-1:0] rd_idx = IW'(rd_row_reg) * IW'(ROW_BYTES) + IW'(rd_byte_reg);
    wire [7:0] rd_data = (src_reg == SRC_STAGE) ? stage_reg[rd_byte_reg] :
                         (src_reg == SRC_ARRAY) ? mem_reg[rd_idx] : `UTM_ERASED_BYTE;
    wire buf_in_ready;

    // read tokens stall while the buffer is full; others always taken
    assign link.tok_ready = (link.tok_kind != utm_pkg::UTM_TOK_READ) || buf_in_ready;
    assign prog_mode_o = prog_mode_reg;
    assign erase_done_o = erase_done_reg;
    assign row_prog_done_o = row_prog_done_reg;

    utm_dev_buf #(.W(8)) u_buf (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .in_valid_i(link.tok_valid && link.tok_kind == utm_pkg::UTM_TOK_READ),
        .in_ready_o(buf_in_ready),
        .in_data_i(rd_data),
        .out_valid_o(link.rsp_valid),
        .out_ready_i(link.rsp_ready),
        .out_data_o(link.rsp_data)
    );

    // programming mode entry and exit
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            prog_mode_reg <= 1'b0;
        end else if (do_enter) begin
            prog_mode_reg <= 1'b1;
        end else if (do_exit) begin
            prog_mode_reg <= 1'b0;
        end
    end

    // write transaction tracking
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            in_write_reg <= 1'b0;
            byte_cnt_reg <= 4'h0;
            instr_reg <= 8'h00;
        end else if (is_start) begin
            in_write_reg <= 1'b1;
            byte_cnt_reg <= 4'h0;
        end else if (is_rstart || is_stop) begin
            in_write_reg <= 1'b0;
        end else if (is_data) begin
            byte_cnt_reg <= (byte_cnt_reg == 4'hF) ? byte_cnt_reg : byte_cnt_reg + 4'h1;
            if (first_byte) begin
                instr_reg <= link.tok_data;
            end
        end
    end

    // key bytes and row-address byte
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            key_hi_ok_reg <= 1'b0;
            key_ok_reg <= 1'b0;
            row_reg <= '0;
        end else if (is_start) begin
            key_hi_ok_reg <= 1'b0;
            key_ok_reg <= 1'b0;
        end else if (arg_byte && arg_idx == 4'h0) begin
            key_hi_ok_reg <= (link.tok_data == `UTM_KEY_HI);
            row_reg <= RW'(link.tok_data[7:`UTM_ROW_LSB]); // low nibble ignored
        end else if (arg_byte && arg_idx == 4'h1) begin
            key_ok_reg <= key_hi_ok_reg && (link.tok_data == `UTM_KEY_LO);
        end
    end

    // read phase pointers; stop drops the source whatever was read so far
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            src_reg <= SRC_NONE;
            rd_row_reg <= '0;
            rd_byte_reg <= '0;
        end else if (is_stop || is_start) begin
            src_reg <= SRC_NONE;
        end else if (is_rstart) begin
            rd_byte_reg <= '0;
            rd_row_reg <= row_reg;
            if (!access_ok) begin
                src_reg <= SRC_NONE;
            end else if (instr_reg == `UTM_INSTR_RD_STAGE) begin
                src_reg <= SRC_STAGE;
            end else if (instr_reg == `UTM_INSTR_RD_ROW) begin
                src_reg <= SRC_ARRAY;
            end else begin
                src_reg <= SRC_NONE;
            end
        end else if (is_read) begin
            rd_byte_reg <= (rd_byte_reg == LAST_BYTE) ? '0 : rd_byte_reg + 1'b1;
            if (src_reg == SRC_ARRAY && rd_byte_reg == LAST_BYTE) begin
                rd_row_reg <= (rd_row_reg == LAST_ROW) ? '0 : rd_row_reg + 1'b1;
            end
        end
    end

    // completion pulses for surrounding logic
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            erase_done_reg <= 1'b0;
            row_prog_done_reg <= 1'b0;
        end else begin
            erase_done_reg <= do_erase;
            row_prog_done_reg <= do_prog;
        end
    end

    // staging bytes; only the addressed byte changes, the rest keep old data
    for (genvar s = 0; s < ROW_BYTES; s++) begin : g_stage
        always_ff @(posedge sys_clk_i) begin
            if (srst_i) begin
                stage_reg[s] <= 8'h00;
            end else if (stage_wr && arg_idx == 4'(s)) begin
                stage_reg[s] <= link.tok_data;
            end
        end
    end

    // array cells; programming can only clear bits, which is why erase comes first
    for (genvar e = 0; e < ENTRIES; e++) begin : g_cell
        always_ff @(posedge sys_clk_i) begin
            if (srst_i) begin
                mem_reg[e] <= `UTM_ERASED_BYTE;
            end else if (do_erase) begin
                mem_reg[e] <= `UTM_ERASED_BYTE;
            end else if (do_prog && row_reg == RW'(e / ROW_BYTES)) begin
                mem_reg[e] <= mem_reg[e] & stage_reg[e % ROW_BYTES];
            end
        end
    end
endmodule

// *** src/utm_host.sv ***
// tag memory host end: turns user operations into link token sequences
`timescale 1ns/1ps
`include "utm_defs.svh"

module utm_host (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // user operation request
    input wire logic op_valid_i,
    output logic op_ready_o,
    input wire utm_pkg::utm_op_e op_code_i,
    input wire logic [3:0] op_row_i,
    input wire logic [6:0] op_len_i,
    input wire logic [55:0] op_wr_data_i,
    output logic op_done_o,
    // read byte stream to user
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [7:0] rd_data_o,
    // link to device
    utm_link_if.host link
);
    // sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_START = 7'b000_0010,
        ST_INSTR = 7'b000_0100,
        ST_ARG = 7'b000_1000,
        ST_RSTART = 7'b001_0000,
        ST_READ = 7'b010_0000,
        ST_STOP = 7'b100_0000
    } utm_hst_e;

    utm_hst_e state_reg;
    utm_hst_e state_next;
    utm_pkg::utm_op_e op_reg; // latched operation
    logic [3:0] row_reg; // latched row
    logic [6:0] len_reg; // latched length
    logic [55:0] wr_reg; // latched write bytes, byte 0 low
    logic [2:0] arg_reg; // argument byte index
    logic [6:0] rd_left_reg; // read requests still to issue
    logic done_reg;

    wire fire = link.tok_valid && link.tok_ready;
    wire is_read_op = (op_reg == utm_pkg::UTM_OP_READ_STAGE) || (op_reg == utm_pkg::UTM_OP_READ_ROW);

    // instruction byte per operation
    wire [7:0] instr = (op_reg == utm_pkg::UTM_OP_ENTER_PROG) ? `UTM_INSTR_PROG_ENTER :
                       (op_reg == utm_pkg::UTM_OP_EXIT_PROG) ? `UTM_INSTR_PROG_EXIT :
                       (op_reg == utm_pkg::UTM_OP_ERASE) ? `UTM_INSTR_ERASE :
                       (op_reg == utm_pkg::UTM_OP_WRITE_STAGE) ? `UTM_INSTR_WR_STAGE :
                       (op_reg == utm_pkg::UTM_OP_READ_STAGE) ? `UTM_INSTR_RD_STAGE :
                       (op_reg == utm_pkg::UTM_OP_PROGRAM_ROW) ? `UTM_INSTR_PROG_ROW : `UTM_INSTR_RD_ROW;

    // argument count per operation; write length capped at seven bytes
    wire [6:0] wr_len = (len_reg > 7'd7) ? 7'd7 : len_reg;
    wire [2:0] n_args = (op_reg == utm_pkg::UTM_OP_ENTER_PROG) ? 3'd2 :
                        (op_reg == utm_pkg::UTM_OP_WRITE_STAGE) ? wr_len[2:0] :
                        (op_reg == utm_pkg::UTM_OP_PROGRAM_ROW || op_reg == utm_pkg::UTM_OP_READ_ROW) ? 3'd1 : 3'd0;

    // argument byte: key, staging data or row address with zero low nibble
    wire [7:0] key_byte = (arg_reg == 3'd0) ? `UTM_KEY_HI : `UTM_KEY_LO;
    wire [7:0] row_byte = {row_reg, 4'h0};
    wire [7:0] arg_byte = (op_reg == utm_pkg::UTM_OP_ENTER_PROG) ? key_byte :
                          (op_reg == utm_pkg::UTM_OP_WRITE_STAGE) ? wr_reg[{arg_reg, 3'b000} +: 8] : row_byte;
    wire last_arg = (arg_reg == n_args - 3'd1);

    // token fields driven from state
    assign link.tok_valid = (state_reg != ST_IDLE);
    assign link.tok_kind = (state_reg == ST_START) ? utm_pkg::UTM_TOK_START_WR :
                           (state_reg == ST_INSTR || state_reg == ST_ARG) ? utm_pkg::UTM_TOK_DATA :
                           (state_reg == ST_RSTART) ? utm_pkg::UTM_TOK_RSTART_RD :
                           (state_reg == ST_READ) ? utm_pkg::UTM_TOK_READ : utm_pkg::UTM_TOK_STOP;
    assign link.tok_data = (state_reg == ST_INSTR) ? instr : (state_reg == ST_ARG) ? arg_byte : 8'h00;
    assign link.tok_last = (state_reg == ST_READ) && (rd_left_reg == 7'd1); // nack on last byte
    assign op_ready_o = (state_reg == ST_IDLE);
    assign op_done_o = done_reg;

    // read bytes pass straight to the user, whose stall reaches the device buffer
    assign rd_valid_o = link.rsp_valid;
    assign rd_data_o = link.rsp_data;
    assign link.rsp_ready = rd_ready_i;

    // next state; every transaction closes with a stop
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (op_valid_i) begin
                    state_next = ST_START;
                end
            end
            ST_START: begin
                if (fire) begin
                    state_next = ST_INSTR;
                end
            end
            ST_INSTR: begin
                if (fire) begin
                    state_next = (n_args != 3'd0) ? ST_ARG : (is_read_op ? ST_RSTART : ST_STOP);
                end
            end
            ST_ARG: begin
                if (fire && last_arg) begin
                    state_next = is_read_op ? ST_RSTART : ST_STOP;
                end
            end
            ST_RSTART: begin
                if (fire) begin
                    state_next = (len_reg != 7'd0) ? ST_READ : ST_STOP;
                end
            end
            ST_READ: begin
                if (fire && rd_left_reg == 7'd1) begin
                    state_next = ST_STOP;
                end
            end
            ST_STOP: begin
                if (fire) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // operation latch, taken only when idle
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            op_reg <= utm_pkg::UTM_OP_EXIT_PROG;
            row_reg <= 4'h0;
            len_reg <= 7'd0;
            wr_reg <= 56'h0000_0000_0000_00;
        end else if (op_valid_i && op_ready_o) begin
            op_reg <= op_code_i;
            row_reg <= op_row_i;
            len_reg <= op_len_i;
            wr_reg <= op_wr_data_i;
        end
    end

    // argument and read counters, done pulse
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            arg_reg <= 3'd0;
            rd_left_reg <= 7'd0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= fire && state_reg == ST_STOP;
            if (state_reg == ST_INSTR) begin
                arg_reg <= 3'd0;
                rd_left_reg <= len_reg;
            end else if (fire && state_reg == ST_ARG) begin
                arg_reg <= arg_reg + 3'd1;
            end else if (fire && state_reg == ST_READ) begin
                rd_left_reg <= rd_left_reg - 7'd1;
            end
        end
    end
endmodule

// *** verification/utm_link_sva.sv ***
// link protocol checker for the tag memory access ends
`timescale 1ns/1ps
module utm_link_sva (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // host to device tokens
    input wire logic tok_valid,
    input wire logic tok_ready,
    input wire utm_pkg::utm_tok_e tok_kind,
    input wire logic [7:0] tok_data,
    input wire logic tok_last,
    // device to host read bytes
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [7:0] rsp_data
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    // read tokens taken and bytes handed back
    wire rd_take = tok_valid && tok_ready && (tok_kind == utm_pkg::UTM_TOK_READ);
    wire rsp_take = rsp_valid && rsp_ready;
    // mirror of the read buffer fill, so stalls can be judged exactly
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    assign cnt_next = cnt_reg + {1'b0, rd_take} - {1'b0, rsp_take};
    // fill count follows takes on both sides
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cnt_reg <= 2'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    property p_tok_hold; tok_valid && !tok_ready |=> tok_valid && $stable(tok_kind) && $stable(tok_data);
    endproperty
    a_tok_hold: assert property (p_tok_hold) else $error("token changed before taken");
    property p_ctl_ready; tok_valid && tok_kind != utm_pkg::UTM_TOK_READ |-> tok_ready;
    endproperty
    a_ctl_ready: assert property (p_ctl_ready) else $error("non-read token refused");
    property p_read_ready; tok_valid && tok_kind == utm_pkg::UTM_TOK_READ |-> tok_ready == (cnt_reg != 2'h2);
    endproperty
    a_read_ready: assert property (p_read_ready) else $error("read stall does not match fill");
    property p_rsp_answer; rd_take && !rsp_valid |=> rsp_valid;
    endproperty
    a_rsp_answer: assert property (p_rsp_answer) else $error("read byte late");
    property p_rsp_count; 1'b1 |-> rsp_valid == (cnt_reg != 2'h0);
    endproperty
    a_rsp_count: assert property (p_rsp_count) else $error("read bytes lost or invented");
    property p_rsp_hold; rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data);
    endproperty
    a_rsp_hold: assert property (p_rsp_hold) else $error("read byte dropped while stalled");
    property p_last_stop; rd_take && tok_last |-> ##[1:20] (tok_valid && tok_kind == utm_pkg::UTM_TOK_STOP);
    endproperty
    a_last_stop: assert property (p_last_stop) else $error("no stop after last read");
    property p_reset_idle; $fell(srst_i) |-> !tok_valid && !rsp_valid;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("link busy after reset");
    // main scenarios reached
    c_read_stall: cover property (tok_valid && tok_kind == utm_pkg::UTM_TOK_READ && !tok_ready);
    c_rsp_stall: cover property (rsp_valid && !rsp_ready);
    c_last_read: cover property (rd_take && tok_last);
endmodule

// *** verification/test_user_tag_memory_access.sv ***
// self-checking bench joining the host and device ends of the tag memory link
`timescale 1ns/1ps
module test_user_tag_memory_access;
    // clock, reset and cycle count
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    int cyc = 0;
    // host user side
    logic op_valid_i = 1'b0;
    logic op_ready_o;
    utm_pkg::utm_op_e op_code_i = utm_pkg::UTM_OP_ENTER_PROG;
    logic [3:0] op_row_i = 4'h0;
    logic [6:0] op_len_i = 7'h00;
    logic [55:0] op_wr_data_i = 56'h0;
    logic op_done_o;
    logic rd_valid_o;
    logic rd_ready_i = 1'b0;
    logic [7:0] rd_data_o;
    // device feature select and status
    logic fault_log_en_i = 1'b0;
    logic prog_mode_o;
    logic erase_done_o;
    logic row_prog_done_o;
    // collected read bytes, expected staging and counters
    logic [7:0] rdq[$];
    logic [55:0] stage = 56'h0;
    logic [1:0] pulse = 2'h0;
    int fails = 0;
    int comparisons = 0;
    utm_link_if link ();
    utm_host utm_host_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .op_valid_i(op_valid_i),
        .op_ready_o(op_ready_o), .op_code_i(op_code_i), .op_row_i(op_row_i), .op_len_i(op_len_i),
        .op_wr_data_i(op_wr_data_i), .op_done_o(op_done_o), .rd_valid_o(rd_valid_o),
        .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .link(link));
    utm_dev utm_dev_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .link(link), .fault_log_en_i(fault_log_en_i),
        .prog_mode_o(prog_mode_o), .erase_done_o(erase_done_o), .row_prog_done_o(row_prog_done_o));
    utm_link_sva utm_link_sva_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .tok_valid(link.tok_valid),
        .tok_ready(link.tok_ready), .tok_kind(link.tok_kind), .tok_data(link.tok_data),
        .tok_last(link.tok_last), .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
        .rsp_data(link.rsp_data));
    always #5 sys_clk_i = ~sys_clk_i;
    // stall reads three cycles in eight so the buffer fills and refuses; hang guard
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        rd_ready_i <= #1 ((cyc % 8) > 2);
        if (cyc == 20000) begin
            fails = fails + 1;
            stop_test();
        end
    end
    // collect every byte handed to the user; sampled mid-cycle where the handshake is settled
    always @(negedge sys_clk_i) begin
        if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
            rdq.push_back(rd_data_o);
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one user operation, entered and left one small delay after an edge
    task automatic op(input utm_pkg::utm_op_e c, input logic [3:0] r, input logic [6:0] n, input logic [55:0] d);
        rdq.delete();
        op_code_i = c;
        op_row_i = r;
        op_len_i = n;
        op_wr_data_i = d;
        op_valid_i = 1'b1;
        while (op_ready_o !== 1'b1) @(posedge sys_clk_i) #1;
        @(posedge sys_clk_i);
        #1 op_valid_i = 1'b0;
        while (op_done_o !== 1'b1) @(posedge sys_clk_i) #1;
        pulse = {erase_done_o, row_prog_done_o};
        if (c == utm_pkg::UTM_OP_READ_ROW || c == utm_pkg::UTM_OP_READ_STAGE) begin
            while (rdq.size() < int'(n)) @(posedge sys_clk_i);
        end
        #1;
    endtask
    // read n bytes; the first nst come from the expected staging, the rest erased
    task automatic rd(input utm_pkg::utm_op_e c, input logic [3:0] r, input int n, input int nst);
        op(c, r, 7'(n), 56'h0);
        for (int k = 0; k < n; k++) begin
            chk(rdq[k], (k < nst) ? stage[8*k +: 8] : 8'hFF);
        end
    endtask
    // tag access outside programming mode has no effect
    task automatic t_blocked();
        op(utm_pkg::UTM_OP_WRITE_STAGE, 4'h0, 7'h01, 56'hAA);
        op(utm_pkg::UTM_OP_PROGRAM_ROW, 4'h3, 7'h00, 56'h0);
        chk({6'h00, pulse}, 8'h00);
        rd(utm_pkg::UTM_OP_READ_ROW, 4'h3, 2, 0);
        chk({7'h00, prog_mode_o}, 8'h00);
        op(utm_pkg::UTM_OP_ENTER_PROG, 4'h0, 7'h00, 56'h0);
        chk({7'h00, prog_mode_o}, 8'h01);
        $display("test blocked and enter done");
    endtask
    // staging written fully, then partly; untouched bytes keep their value
    task automatic t_stage();
        rd(utm_pkg::UTM_OP_READ_STAGE, 4'h0, 7, 7);
        stage = 56'h77_6655_4433_2211;
        op(utm_pkg::UTM_OP_WRITE_STAGE, 4'h0, 7'h07, stage);
        rd(utm_pkg::UTM_OP_READ_STAGE, 4'h0, 7, 7);
        op(utm_pkg::UTM_OP_WRITE_STAGE, 4'h0, 7'h02, 56'hB0A0);
        stage[15:0] = 16'hB0A0;
        rd(utm_pkg::UTM_OP_READ_STAGE, 4'h0, 7, 7);
        $display("test staging done");
    endtask
    // program the last row, read across the wrap, then erase the whole array
    task automatic t_prog();
        rd(utm_pkg::UTM_OP_READ_ROW, 4'h3, 7, 0);
        op(utm_pkg::UTM_OP_PROGRAM_ROW, 4'hF, 7'h00, 56'h0);
        chk({6'h00, pulse}, 8'h01);
        rd(utm_pkg::UTM_OP_READ_ROW, 4'hF, 9, 7);
        op(utm_pkg::UTM_OP_PROGRAM_ROW, 4'h1, 7'h00, 56'h0);
        rd(utm_pkg::UTM_OP_READ_ROW, 4'h1, 3, 7);
        op(utm_pkg::UTM_OP_ERASE, 4'h0, 7'h00, 56'h0);
        chk({6'h00, pulse}, 8'h02);
        rd(utm_pkg::UTM_OP_READ_ROW, 4'h1, 7, 0);
        op(utm_pkg::UTM_OP_PROGRAM_ROW, 4'h1, 7'h00, 56'h0);
        rd(utm_pkg::UTM_OP_READ_ROW, 4'h1, 7, 7);
        rd(utm_pkg::UTM_OP_READ_ROW, 4'hF, 1, 0);
        $display("test program and erase done");
    endtask
    // fault logging enabled blocks tag access; then leave programming mode
    task automatic t_fault_exit();
        fault_log_en_i = 1'b1;
        op(utm_pkg::UTM_OP_WRITE_STAGE, 4'h0, 7'h01, 56'h55);
        rd(utm_pkg::UTM_OP_READ_STAGE, 4'h0, 1, 0);
        fault_log_en_i = 1'b0;
        rd(utm_pkg::UTM_OP_READ_STAGE, 4'h0, 7, 7);
        op(utm_pkg::UTM_OP_EXIT_PROG, 4'h0, 7'h00, 56'h0);
        chk({7'h00, prog_mode_o}, 8'h00);
        rd(utm_pkg::UTM_OP_READ_STAGE, 4'h0, 1, 0);
        $display("test fault and exit done");
    endtask
    task automatic stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // reset for two cycles, then the scenarios in order
    initial begin
        repeat (2) @(posedge sys_clk_i);
        #1 srst_i = 1'b0;
        @(posedge sys_clk_i);
        #1;
        t_blocked();
        t_stage();
        t_prog();
        t_fault_exit();
        stop_test();
    end
endmodule
